//--- hdl/pfmux_consts.svh
`ifndef PFMUX_CONSTS_SVH
`define PFMUX_CONSTS_SVH
// How it works
// R1 - uart a swap exchanges its tx and rx pins; swapped tx drives the reset pin only in port mode
// R2 - uart b swap exchanges its tx and rx pins
// R3 - twi remap moves scl/sda to alternate pins
// R4 - adc trigger remap moves trigger to p0.3
// R5 - per-pin select picks pwm or gpio drive
// R6 - low reset pin resets whole device
// R7 - reset pin is port input when disabled
// R8 - oscillator pin is port when internal clock
// R9 - external clock mode takes clock from pin
// R10 - every pin may raise a pin interrupt
// R11 - timer pins count input and toggle output
// R12 - reset clears all remap and swap selects
`define PFMUX_NPIN 12
`define PFMUX_P00 0
`define PFMUX_P01 1
`define PFMUX_P02 2
`define PFMUX_P03 3
`define PFMUX_P04 4
`define PFMUX_P05 5
`define PFMUX_P06 6
`define PFMUX_P10 7
`define PFMUX_P16 8
`define PFMUX_P17 9
`define PFMUX_P20 10
`define PFMUX_P30 11
`define PFMUX_NPWM 6
`define PFMUX_BIT_UA_SWAP 2
`define PFMUX_BIT_UB_SWAP 1
`define PFMUX_BIT_TWI_REMAP 0
`define PFMUX_BIT_ADC_REMAP 6
`define PFMUX_BIT_RPD 2
`define PFMUX_BIT_EXTERNAL_CLOCK_MODE 8
`define PFMUX_CFG0_RESET 8'hFF
`define PFMUX_A_AUX 32'h00000000
`define PFMUX_A_TWI 32'h00000004
`define PFMUX_A_ADC 32'h00000008
`define PFMUX_A_PWM 32'h0000000C
`define PFMUX_A_CFG 32'h00000010
`define PFMUX_A_PIN 32'h00000014
`define PFMUX_A_INT 32'h00000018
`define PFMUX_A_IFL 32'h0000001C
`define PFMUX_RESP_OK 2'h0
`define PFMUX_RESP_ERR 2'h2
`endif

//--- hdl/pfmux_pkg.sv
package pfmux_pkg;
    typedef logic [11:0] pfmux_pins_t;
    typedef logic [7:0] pfmux_byte_t;
    typedef logic [5:0] pfmux_pwm_t;
endpackage : pfmux_pkg

//--- hdl/pfmux_axil.sv
`include "pfmux_consts.svh"
// axi4-lite slave: one write and one read; a write is answered one cycle after both halves are taken, a read on the edge that takes its address
module pfmux_axil (
    input wire logic clk_sys,
    input wire logic reset_n,
    // write channels
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register side
    output logic wr_en,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    output logic [31:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok,
    input wire logic wr_ok
);
    logic aw_have_r;
    logic w_have_r;
    logic [31:0] aw_r;
    logic [31:0] w_r;
    logic [3:0] s_r;

    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready = !w_have_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_en = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_addr = aw_r;
    assign wr_data = w_r;
    assign wr_strb = s_r;
    assign rd_addr = s_axi_araddr;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_r <= 32'h00000000;
            w_r <= 32'h00000000;
            s_r <= 4'h0;
        end else if (wr_en) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_r <= s_axi_wdata;
                s_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PFMUX_RESP_OK;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `PFMUX_RESP_OK : `PFMUX_RESP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PFMUX_RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ok ? rd_data : 32'h00000000;
            s_axi_rresp <= rd_ok ? `PFMUX_RESP_OK : `PFMUX_RESP_ERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_write_answer: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_en |=> s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule : pfmux_axil

//--- hdl/pfmux_top.sv
`include "pfmux_consts.svh"
// pin function mux for the small packages; pins indexed by PFMUX_Pxx
module pfmux_top (
    input wire logic clk_sys,
    input wire logic reset_n,
    // axi4-lite
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // package pins
    input wire pfmux_pkg::pfmux_pins_t pin_in,
    output pfmux_pkg::pfmux_pins_t pin_out,
    output pfmux_pkg::pfmux_pins_t pin_oe_n,
    // gpio port logic
    input wire pfmux_pkg::pfmux_pins_t gpio_out,
    input wire pfmux_pkg::pfmux_pins_t gpio_oe_n,
    output pfmux_pkg::pfmux_pins_t gpio_in,
    // pwm generator, channels 0..5
    input wire pfmux_pkg::pfmux_pwm_t pwm_ch,
    // uarts
    input wire logic uart_a_txd,
    output logic uart_a_rxd,
    input wire logic uart_b_txd,
    output logic uart_b_rxd,
    // twi open drain, drive low when oe_n low
    input wire logic twi_scl_drive_low,
    input wire logic twi_sda_drive_low,
    output logic twi_scl_in,
    output logic twi_sda_in,
    // adc trigger, timers
    output logic adc_start_trigger_in,
    output logic timer0_count_in,
    output logic timer1_count_in,
    input wire logic timer0_toggle_out,
    input wire logic timer1_toggle_out,
    input wire logic timer0_toggle_en,
    input wire logic timer1_toggle_en,
    // clocking and reset
    input wire logic internal_osc_selected,
    output logic external_clock_in,
    output logic pin_reset_req,
    // pin interrupts
    output pfmux_pkg::pfmux_pins_t pin_irq_req
);
    import pfmux_pkg::*;

    pfmux_byte_t auxiliary_control_reg_r;
    pfmux_byte_t twi_control_reg_r;
    pfmux_byte_t adc_control_reg_one_r;
    pfmux_pwm_t pwm_pin_select_reg_r;
    pfmux_byte_t config_byte_zero_r;
    logic external_clock_mode_r;
    pfmux_pins_t pin_int_en_r;
    pfmux_pins_t pin_int_flag_r;
    pfmux_pins_t pin_prev_r;
    pfmux_pins_t drv_out;
    pfmux_pins_t drv_oe_n;
    logic wr_en;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic wr_ok;
    logic uart_a_pin_swap;
    logic uart_b_pin_swap;
    logic twi_pin_remap;
    logic adc_trigger_pin_remap;
    logic reset_pin_disable;

    function automatic logic addr_hit(input logic [31:0] a);
        addr_hit = (a == `PFMUX_A_AUX) || (a == `PFMUX_A_TWI) || (a == `PFMUX_A_ADC) ||
            (a == `PFMUX_A_PWM) || (a == `PFMUX_A_CFG) || (a == `PFMUX_A_PIN) ||
            (a == `PFMUX_A_INT) || (a == `PFMUX_A_IFL);
    endfunction : addr_hit

    pfmux_axil u_axil (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok),
        .wr_ok(wr_ok)
    );

    assign wr_ok = addr_hit(wr_addr) && (wr_addr != `PFMUX_A_PIN);
    assign rd_ok = addr_hit(rd_addr);

    assign uart_a_pin_swap = auxiliary_control_reg_r[`PFMUX_BIT_UA_SWAP];
    assign uart_b_pin_swap = auxiliary_control_reg_r[`PFMUX_BIT_UB_SWAP];
    assign twi_pin_remap = twi_control_reg_r[`PFMUX_BIT_TWI_REMAP];
    assign adc_trigger_pin_remap = adc_control_reg_one_r[`PFMUX_BIT_ADC_REMAP];
    assign reset_pin_disable = config_byte_zero_r[`PFMUX_BIT_RPD];

    // select registers: byte lane 0 only; selects clear at reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            auxiliary_control_reg_r <= 8'h00; // [R12]
            twi_control_reg_r <= 8'h00; // [R12]
            adc_control_reg_one_r <= 8'h00; // [R12]
            pwm_pin_select_reg_r <= 6'h00;
        end else if (wr_en && wr_strb[0]) begin
            case (wr_addr)
                `PFMUX_A_AUX: auxiliary_control_reg_r <= wr_data[7:0];
                `PFMUX_A_TWI: twi_control_reg_r <= wr_data[7:0];
                `PFMUX_A_ADC: adc_control_reg_one_r <= wr_data[7:0];
                `PFMUX_A_PWM: pwm_pin_select_reg_r <= wr_data[5:0];
                default: ;
            endcase
        end
    end

    // config image: erased flash reads all ones, so reset pin stays a reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            config_byte_zero_r <= `PFMUX_CFG0_RESET;
            external_clock_mode_r <= 1'b0;
        end else if (wr_en && wr_strb[0] && wr_addr == `PFMUX_A_CFG) begin
            config_byte_zero_r <= wr_data[7:0];
            external_clock_mode_r <= wr_data[`PFMUX_BIT_EXTERNAL_CLOCK_MODE];
        end
    end

    // pin interrupts: edge on an enabled pin sets a sticky flag, write one clears
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_int_en_r <= 12'h000;
            pin_int_flag_r <= 12'h000;
            // pins idle high, so no false edge follows reset
            pin_prev_r <= 12'hFFF;
        end else begin
            pin_prev_r <= pin_in;
            if (wr_en && wr_strb[0] && wr_addr == `PFMUX_A_INT) begin
                pin_int_en_r <= wr_data[11:0];
            end
            if (wr_en && wr_strb[0] && wr_addr == `PFMUX_A_IFL) begin
                pin_int_flag_r <= (pin_int_flag_r & ~wr_data[11:0]) |
                    (pin_int_en_r & (pin_in ^ pin_prev_r)); // [R10]
            end else begin
                pin_int_flag_r <= pin_int_flag_r | (pin_int_en_r & (pin_in ^ pin_prev_r)); // [R10]
            end
        end
    end
    assign pin_irq_req = pin_int_flag_r;

    always_comb begin
        rd_data = 32'h00000000;
        case (rd_addr)
            `PFMUX_A_AUX: rd_data[7:0] = auxiliary_control_reg_r;
            `PFMUX_A_TWI: rd_data[7:0] = twi_control_reg_r;
            `PFMUX_A_ADC: rd_data[7:0] = adc_control_reg_one_r;
            `PFMUX_A_PWM: rd_data[5:0] = pwm_pin_select_reg_r;
            `PFMUX_A_CFG: rd_data[8:0] = {external_clock_mode_r, config_byte_zero_r};
            `PFMUX_A_PIN: rd_data[11:0] = pin_in;
            `PFMUX_A_INT: rd_data[11:0] = pin_int_en_r;
            `PFMUX_A_IFL: rd_data[11:0] = pin_int_flag_r;
            default: rd_data = 32'h00000000;
        endcase
    end

    // output drive per pin; peripherals override gpio where selected
    always_comb begin
        drv_out = gpio_out;
        drv_oe_n = gpio_oe_n;
        // pwm0 ch3 on p0.0, ch4 p0.1, ch0 p0.2, ch5 p0.3, ch3 p0.4, ch2 p0.5 [R5]
        if (pwm_pin_select_reg_r[0]) begin
            drv_out[`PFMUX_P00] = pwm_ch[3]; // [R5]
            drv_oe_n[`PFMUX_P00] = 1'b0;
        end
        if (pwm_pin_select_reg_r[1]) begin
            drv_out[`PFMUX_P01] = pwm_ch[4]; // [R5]
            drv_oe_n[`PFMUX_P01] = 1'b0;
        end
        if (pwm_pin_select_reg_r[2]) begin
            drv_out[`PFMUX_P02] = pwm_ch[0]; // [R5]
            drv_oe_n[`PFMUX_P02] = 1'b0;
        end
        if (pwm_pin_select_reg_r[3]) begin
            drv_out[`PFMUX_P03] = pwm_ch[5]; // [R5]
            drv_oe_n[`PFMUX_P03] = 1'b0;
        end
        if (pwm_pin_select_reg_r[4]) begin
            drv_out[`PFMUX_P04] = pwm_ch[3]; // [R5]
            drv_oe_n[`PFMUX_P04] = 1'b0;
        end
        if (pwm_pin_select_reg_r[5]) begin
            drv_out[`PFMUX_P05] = pwm_ch[2]; // [R5]
            drv_oe_n[`PFMUX_P05] = 1'b0;
        end
        // timer toggle outputs share the count input pins
        if (timer1_toggle_en) begin
            drv_out[`PFMUX_P00] = timer1_toggle_out; // [R11]
            drv_oe_n[`PFMUX_P00] = 1'b0;
        end
        if (timer0_toggle_en) begin
            drv_out[`PFMUX_P05] = timer0_toggle_out; // [R11]
            drv_oe_n[`PFMUX_P05] = 1'b0;
        end
        // twi is open drain: only ever pulls low
        if (twi_scl_drive_low) begin
            drv_out[twi_pin_remap ? `PFMUX_P02 : `PFMUX_P03] = 1'b0; // [R3]
            drv_oe_n[twi_pin_remap ? `PFMUX_P02 : `PFMUX_P03] = 1'b0;
        end
        if (twi_sda_drive_low) begin
            drv_out[twi_pin_remap ? `PFMUX_P16 : `PFMUX_P04] = 1'b0; // [R3]
            drv_oe_n[twi_pin_remap ? `PFMUX_P16 : `PFMUX_P04] = 1'b0;
        end
        // uart a tx on p0.6 normally, on the reset/port 2 pin when swapped
        drv_out[uart_a_pin_swap ? `PFMUX_P20 : `PFMUX_P06] = uart_a_txd; // [R1]
        drv_oe_n[uart_a_pin_swap ? `PFMUX_P20 : `PFMUX_P06] = 1'b0;
        drv_out[uart_b_pin_swap ? `PFMUX_P02 : `PFMUX_P16] = uart_b_txd; // [R2]
        drv_oe_n[uart_b_pin_swap ? `PFMUX_P02 : `PFMUX_P16] = 1'b0;
        // reset pin drives only as swapped uart tx in port mode; osc pin only as a port
        if (reset_pin_disable || !uart_a_pin_swap) begin
            drv_oe_n[`PFMUX_P20] = 1'b1; // [R7]
            drv_out[`PFMUX_P20] = 1'b0;
        end
        if (!internal_osc_selected || external_clock_mode_r) begin
            drv_oe_n[`PFMUX_P30] = 1'b1; // [R8]
            drv_out[`PFMUX_P30] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_out <= 12'h000;
            pin_oe_n <= 12'hFFF;
        end else begin
            pin_out <= drv_out;
            pin_oe_n <= drv_oe_n;
        end
    end

    // input routing
    always_comb begin
        gpio_in = pin_in;
        if (reset_pin_disable) begin
            gpio_in[`PFMUX_P20] = 1'b1; // [R7]
        end
        if (!internal_osc_selected || external_clock_mode_r) begin
            gpio_in[`PFMUX_P30] = 1'b0; // [R8]
        end
    end
    assign uart_a_rxd = uart_a_pin_swap ? pin_in[`PFMUX_P06] : pin_in[`PFMUX_P20]; // [R1]
    assign uart_b_rxd = uart_b_pin_swap ? pin_in[`PFMUX_P16] : pin_in[`PFMUX_P02]; // [R2]
    assign twi_scl_in = twi_pin_remap ? pin_in[`PFMUX_P02] : pin_in[`PFMUX_P03]; // [R3]
    assign twi_sda_in = twi_pin_remap ? pin_in[`PFMUX_P16] : pin_in[`PFMUX_P04]; // [R3]
    assign adc_start_trigger_in = adc_trigger_pin_remap ?
        pin_in[`PFMUX_P03] : pin_in[`PFMUX_P04]; // [R4]
    assign timer0_count_in = pin_in[`PFMUX_P05]; // [R11]
    assign timer1_count_in = pin_in[`PFMUX_P00]; // [R11]
    assign external_clock_in = external_clock_mode_r & pin_in[`PFMUX_P30]; // [R9]
    // the pin already passed a schmitt input with pull-up; low means reset
    assign pin_reset_req = reset_pin_disable & ~pin_in[`PFMUX_P20]; // [R6]

    a_twi_remap: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R3]
        twi_pin_remap |-> twi_sda_in == pin_in[`PFMUX_P16])
        else $error("twi sda not on alternate pin");
    a_adc_remap: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R4]
        !adc_trigger_pin_remap |-> adc_start_trigger_in == pin_in[`PFMUX_P04])
        else $error("adc trigger not on primary pin");
    a_uart_a_swap: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R1]
        uart_a_pin_swap && !reset_pin_disable |=>
            pin_out[`PFMUX_P20] == $past(uart_a_txd) && !pin_oe_n[`PFMUX_P20])
        else $error("uart a tx not swapped");
    a_uart_b_swap: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R2]
        !uart_b_pin_swap |-> uart_b_rxd == pin_in[`PFMUX_P02])
        else $error("uart b rx wrong pin");
    a_pwm_drive: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R5]
        pwm_pin_select_reg_r[3] && !twi_scl_drive_low && !twi_pin_remap |=>
            pin_out[`PFMUX_P03] == $past(pwm_ch[5]))
        else $error("pwm not on pin");
    a_reset_pin: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R6]
        reset_pin_disable && !pin_in[`PFMUX_P20] |-> pin_reset_req)
        else $error("reset pin ignored");
    a_port_two: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R7]
        !reset_pin_disable |-> !pin_reset_req && gpio_in[`PFMUX_P20] == pin_in[`PFMUX_P20])
        else $error("port pin caused reset");
    a_osc_pin: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R9]
        external_clock_mode_r |-> external_clock_in == pin_in[`PFMUX_P30])
        else $error("external clock not taken");
    a_osc_port: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R8]
        !internal_osc_selected |-> gpio_in[`PFMUX_P30] == 1'b0)
        else $error("osc pin used as port");
    a_pin_irq: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R10]
        pin_int_en_r[0] && $changed(pin_in[0]) |=> pin_irq_req[0])
        else $error("pin edge lost");
    a_timer_in: assert property (@(posedge clk_sys) disable iff (!reset_n) // [R11]
        timer0_count_in == pin_in[`PFMUX_P05])
        else $error("timer 0 input wrong");
    a_sel_reset: assert property (@(posedge clk_sys) // [R12]
        $rose(reset_n) |-> !uart_a_pin_swap && !uart_b_pin_swap && !twi_pin_remap &&
            !adc_trigger_pin_remap)
        else $error("selects not cleared");
    c_twi_remap: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(twi_pin_remap));
    c_uart_swap: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(uart_a_pin_swap));
    c_pin_irq: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(pin_irq_req[3]));
endmodule : pfmux_top

//--- verification/pfmux_board.sv
// board side of the package pins: device drive wins, then bench drivers, else pull-up
module pfmux_board (
    // device side
    input wire pfmux_pkg::pfmux_pins_t pin_out,
    input wire pfmux_pkg::pfmux_pins_t pin_oe_n,
    output pfmux_pkg::pfmux_pins_t pin_in,
    // outside drivers commanded by the bench
    input wire pfmux_pkg::pfmux_pins_t ext_val,
    input wire pfmux_pkg::pfmux_pins_t ext_en
);
    timeunit 1ns;
    timeprecision 1ns;
    import pfmux_pkg::*;
    // released pins that the bench does not drive float high through the pull-ups
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) |
        (pin_oe_n & ~ext_en);
endmodule : pfmux_board

//--- verification/test_pin_function_mux.sv
`include "pfmux_consts.svh"
module test_pin_function_mux;
    timeunit 1ns;
    timeprecision 1ns;
    import pfmux_pkg::*;
    logic clk_sys, reset_n;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, e, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    pfmux_pins_t pin_in, pin_out, pin_oe_n, gpio_out, gpio_oe_n, gpio_in, pin_irq_req;
    pfmux_pins_t ext_val, ext_en;
    pfmux_pwm_t pwm_ch;
    logic uart_a_txd, uart_a_rxd, uart_b_txd, uart_b_rxd, twi_scl_drive_low, twi_sda_drive_low;
    logic twi_scl_in, twi_sda_in, adc_start_trigger_in, timer0_count_in, timer1_count_in;
    logic timer0_toggle_out, timer1_toggle_out, timer0_toggle_en, timer1_toggle_en;
    logic internal_osc_selected, external_clock_in, pin_reset_req;
    int miscompares, comparisons;
    localparam int chmap [6] = '{3, 4, 0, 5, 3, 2};

    pfmux_top u_pfmux_top (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe_n, .gpio_out, .gpio_oe_n,
        .gpio_in, .pwm_ch, .uart_a_txd, .uart_a_rxd, .uart_b_txd, .uart_b_rxd, .twi_scl_drive_low,
        .twi_sda_drive_low, .twi_scl_in, .twi_sda_in, .adc_start_trigger_in, .timer0_count_in,
        .timer1_count_in, .timer0_toggle_out, .timer1_toggle_out, .timer0_toggle_en,
        .timer1_toggle_en, .internal_osc_selected, .external_clock_in, .pin_reset_req,
        .pin_irq_req);
    pfmux_board u_pfmux_board (.pin_out, .pin_oe_n, .pin_in, .ext_val, .ext_en);

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask : axw

    task automatic axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask : axr

    task automatic step;
        repeat (2) @(posedge clk_sys);
    endtask : step

    // pins 0..5: pwm channel when selected, else port drive
    function automatic logic [31:0] pwm_exp(logic [5:0] s, logic [5:0] ch, logic [5:0] go,
                                            logic [5:0] gn);
        logic [5:0] o, n;
        for (int i = 0; i < 6; i++) begin
            o[i] = s[i] ? ch[chmap[i]] : go[i];
            n[i] = s[i] ? 1'b0 : gn[i];
        end
        return {20'h0, o, n};
    endfunction : pwm_exp

    task automatic end_sim;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        end_sim;
    end

    initial begin
        {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, gpio_out, pwm_ch} = '0;
        {uart_a_txd, uart_b_txd, twi_scl_drive_low, twi_sda_drive_low} = '0;
        {timer0_toggle_out, timer1_toggle_out, timer0_toggle_en, timer1_toggle_en} = '0;
        s_axi_wstrb = 4'hF;
        internal_osc_selected = 1'b1;
        {gpio_oe_n, ext_val, ext_en} = '1;
        void'($urandom(32'hd5ce71f7));
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        for (int a = 0; a < 32; a += 4) begin
            if (a != 20) axr(32'(a), (a == 16) ? 32'h000000FF : 32'h0, 2'h0);
        end
        axr(32'h00000020, 32'h0, 2'h2);
        axw(`PFMUX_A_PIN, 32'h0000000F, 2'h2);
        $display("test reset_values done");
        for (int k = 1; k < 9; k++) begin
            axw(`PFMUX_A_AUX, {29'h0, k[0], k[0], 1'b0}, 2'h0);
            e = $urandom;
            ext_val <= e[11:0];
            uart_a_txd <= e[12];
            uart_b_txd <= e[13];
            step;
            if (k[0]) chk(32'({uart_a_rxd, pin_out[2], pin_oe_n[2], uart_b_rxd}),
                32'({e[6], e[13], 1'b0, e[8]}));
            else chk(32'({pin_out[6], pin_oe_n[6], pin_out[8], uart_b_rxd}),
                32'({e[12], 1'b0, e[13], e[2]}));
        end
        $display("test uart_swap done");
        for (int k = 1; k < 9; k++) begin
            axw(`PFMUX_A_TWI, 32'(k[0]), 2'h0);
            axw(`PFMUX_A_ADC, 32'(k[0]) << 6, 2'h0);
            e = $urandom;
            ext_val <= e[11:0];
            uart_b_txd <= e[13];
            twi_scl_drive_low <= e[14];
            step;
            chk(32'({twi_scl_in, twi_sda_in, adc_start_trigger_in, pin_oe_n[3 - k[0]]}),
                32'({~e[14] & (k[0] ? e[2] : e[3]), k[0] ? e[13] : e[4],
                k[0] ? e[3] : e[4], ~e[14]}));
        end
        twi_scl_drive_low <= 1'b0;
        $display("test twi_adc_remap done");
        for (int k = 0; k < 10; k++) begin
            rd = (k == 0) ? 32'h3F : (k == 1) ? 32'h0 : ($urandom & 32'h3F);
            axw(`PFMUX_A_PWM, rd, 2'h0);
            e = $urandom;
            pwm_ch <= e[5:0];
            gpio_out <= e[17:6];
            gpio_oe_n <= e[29:18];
            step;
            chk(32'({pin_out[5:0], pin_oe_n[5:0]}),
                pwm_exp(rd[5:0], e[5:0], e[11:6], e[23:18]));
        end
        gpio_oe_n <= 12'hFFF;
        axw(`PFMUX_A_PWM, 32'h0, 2'h0);
        $display("test pwm_select done");
        for (int k = 0; k < 8; k++) begin
            e = $urandom;
            {timer1_toggle_out, timer1_toggle_en, timer0_toggle_out, timer0_toggle_en} <= e[3:0];
            ext_val <= e[15:4];
            step;
            chk(32'({pin_out[5] & e[0], pin_oe_n[5], timer0_count_in,
                pin_out[0] & e[2], pin_oe_n[0], timer1_count_in}),
                32'({e[1] & e[0], ~e[0], e[0] ? e[1] : e[9],
                e[3] & e[2], ~e[2], e[2] ? e[3] : e[4]}));
        end
        {timer0_toggle_en, timer1_toggle_en} <= 2'h0;
        $display("test timer_pins done");
        for (int k = 0; k < 8; k++) begin
            axw(`PFMUX_A_CFG, {23'h0, k[1], 5'h1F, ~k[0], 2'h3}, 2'h0);
            e = $urandom;
            ext_val <= e[11:0];
            internal_osc_selected <= ~k[1];
            step;
            chk(32'({pin_reset_req, gpio_in[10], gpio_in[11], external_clock_in & k[1]}),
                32'({~k[0] & ~e[10], k[0] ? e[10] : 1'b1,
                ~k[1] & e[11], k[1] & e[11]}));
        end
        // reset pin is a port now, so the swapped uart a tx must appear on it
        axw(`PFMUX_A_AUX, 32'h4, 2'h0);
        step;
        chk(32'({pin_out[10], pin_oe_n[10]}), 32'({uart_a_txd, 1'b0}));
        $display("test reset_and_clock_pins done");
        for (int k = 0; k < 6; k++) begin
            rd = $urandom & 32'hFFF;
            axw(`PFMUX_A_INT, rd, 2'h0);
            e = $urandom & 32'h2BF;
            ext_val <= ext_val ^ e[11:0];
            step;
            axr(`PFMUX_A_IFL, rd & e, 2'h0);
            chk(32'(pin_irq_req), rd & e);
            axw(`PFMUX_A_IFL, 32'hFFF, 2'h0);
            axr(`PFMUX_A_IFL, 32'h0, 2'h0);
        end
        $display("test pin_interrupts done");
        end_sim;
    end
endmodule : test_pin_function_mux
